// [hw/osc_startup_pkg.sv]
// Constants and types for oscillator selection and start-up control
package osc_startup_pkg;

  // ****************************************
  // Clock rates and timing
  // ****************************************
  localparam int unsigned CLK_HZ   = 200_000_000;
  localparam int unsigned FAST_HZ  = 16_000_000;
  localparam int unsigned MID_HZ   = 500_000;
  localparam int unsigned SLOW_HZ  = 31_250;
  // Integer dividers: the fast tick comes out at 16.7 MHz, not 16
  localparam int unsigned FAST_DIV = CLK_HZ / FAST_HZ;
  localparam int unsigned MID_DIV  = CLK_HZ / MID_HZ;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;

  localparam int unsigned XTAL_EDGES     = 1024;
  localparam int unsigned INSTR_CLKS     = 4;
  localparam int unsigned EXT_WAIT_INSTR = 2;
  localparam int unsigned EXT_WAIT_EDGES = EXT_WAIT_INSTR * INSTR_CLKS;
  localparam int unsigned PLL_LOCK_MS    = 2;
  localparam int unsigned PLL_LOCK_CYC   = CLK_HZ / 1000 * PLL_LOCK_MS;
  localparam int unsigned SWITCH_US      = 1;
  localparam int unsigned SWITCH_CYC     = CLK_HZ / 1_000_000 * SWITCH_US;
  localparam int unsigned PUP_US         = 1000;
  localparam int unsigned PUP_CYC        = CLK_HZ / 1_000_000 * PUP_US;
  localparam int unsigned ISTART_US      = 5;
  localparam int unsigned ISTART_CYC     = CLK_HZ / 1_000_000 * ISTART_US;
  localparam int unsigned CNT_W          = 24;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  STAT_OFS = 8'h04;
  localparam logic [7:0]  CNT_OFS  = 8'h08;

  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_IRC_BIT  = 2;
  localparam int unsigned CTRL_TWO_BIT  = 3;
  localparam int unsigned CTRL_PUP_BIT  = 4;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0110;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_0f1f;

  localparam int unsigned STAT_RUN_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_SRC_LSB  = 2;
  localparam int unsigned STAT_ST_LSB   = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Oscillator modes and select codes
  // ****************************************
  localparam logic [3:0] MODE_LOW_POWER_CRYSTAL  = 4'h0;
  localparam logic [3:0] MODE_MEDIUM_CRYSTAL     = 4'h1;
  localparam logic [3:0] MODE_FAST_CRYSTAL       = 4'h2;
  localparam logic [3:0] MODE_RESISTOR_CAPACITOR = 4'h3;
  localparam logic [3:0] MODE_DRIVEN_LOW_POWER   = 4'h4;
  localparam logic [3:0] MODE_DRIVEN_MID_POWER   = 4'h5;
  localparam logic [3:0] MODE_DRIVEN_HIGH_POWER  = 4'h6;
  localparam logic [3:0] MODE_TIMES_FOUR         = 4'h7;
  localparam logic [3:0] MODE_INTERNAL           = 4'h8;

  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SLOW    = 2'h1;

  typedef enum logic [1:0] {
    SRC_PRIMARY, SRC_FAST, SRC_MID, SRC_SLOW
  } src_e;

  typedef enum logic [3:0] {
    S_PUP, S_COUNT, S_PLL, S_EXT_WAIT, S_INT_WAIT, S_RUN, S_SWITCH,
    S_SLEEP
  } state_e;

  // ****************************************
  // Register bus carriers
  // ****************************************
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage

// [hw/osc_tick_gen.sv]
// Free-running divider that models one internal oscillator as a tick
`timescale 1ns/10ps
`default_nettype none
module osc_tick_gen #(
  parameter int unsigned DIV = 12
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Tick
  output logic      tick_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r + 16'h0001;
    if (cnt_r == 16'(DIV - 1))
    begin
      cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_o = (cnt_r == 16'(DIV - 1));

endmodule
`default_nettype wire

// [hw/osc_startup_ctrl.sv]
// Oscillator source selection and start-up sequencing with a register bus
// Contract
// - Fast, mid and slow internal oscillators are selectable clock sources.
// - The two-bit select field picks between external and internal sources.
// - Crystal modes count 1024 crystal input edges before use.
// - The count starts after power-on (after the optional delay) and wake.
// - While the count runs, execution is held.
// - Any source switch inserts a settling delay.
// - Driven-clock and RC modes wait 2 instruction cycles after start.
// - Slow internal to driven or RC waits one cycle of each clock.
// - Times-four mode waits 1024 counted edges plus 2 ms.
// - Slow internal to another internal waits about 1 us.
// - Two-speed start-up runs code on the fast internal clock meanwhile.
// - Driven-clock mode takes the input pin and frees the output pin.
// - Driven-clock mode has low, mid and high power variants.
// - Driven-clock mode bypasses the crystal edge count.
// - Logic is static: no source edge, no progress, state kept.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module osc_startup_ctrl
  import osc_startup_pkg::*;
#(
  parameter int unsigned PUP_CYCLES_P  = PUP_CYC,
  parameter int unsigned PLL_CYCLES_P  = PLL_LOCK_CYC,
  parameter int unsigned SLOW_DIV_P    = SLOW_DIV
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Register bus
  input  wire axil_req_s  axil_req_i,
  output axil_rsp_s       axil_rsp_o,
  // Oscillator pins
  input  wire logic       crystal_in_i,
  output logic            crystal_out_o,
  output logic            crystal_out_oe_o,
  input  wire logic       gpio_out_i,
  input  wire logic       gpio_oe_i,
  // Core events
  input  wire logic       brownout_i,
  input  wire logic       sleep_i,
  input  wire logic       wake_i,
  // Clock to the core
  output logic            run_o,
  output logic            sys_clk_en_o,
  output logic            startup_busy_o,
  output logic [1:0]      active_src_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    state_e              st;
    src_e                active;
    src_e                target;
    logic [CNT_W-1:0]    cnt;
    logic                phase;
    logic [31:0]         ctrl;
    logic                aw_got;
    logic                w_got;
    logic [ADDR_W-1:0]   awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0]          xin_sync;
    logic                xin_prev;
    logic                xout;
    logic                xout_oe;
    logic                clk_en;
  } state_s;

  state_s r;
  state_s nxt;

  logic fast_tick;
  logic mid_tick;
  logic slow_tick;

  // ****************************************
  // Internal oscillators
  // ****************************************
  // three internal sources
  osc_tick_gen #(.DIV(FAST_DIV)) u_fast (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (fast_tick)
  );
  osc_tick_gen #(.DIV(MID_DIV)) u_mid (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (mid_tick)
  );
  osc_tick_gen #(.DIV(SLOW_DIV_P)) u_slow (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (slow_tick)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_crystal(input logic [3:0] m);
    return (m == MODE_LOW_POWER_CRYSTAL) || (m == MODE_MEDIUM_CRYSTAL) ||
           (m == MODE_FAST_CRYSTAL) || (m == MODE_TIMES_FOUR);
  endfunction

  function automatic logic is_driven(input logic [3:0] m);
    return (m == MODE_DRIVEN_LOW_POWER) || (m == MODE_DRIVEN_MID_POWER) ||
           (m == MODE_DRIVEN_HIGH_POWER) || (m == MODE_RESISTOR_CAPACITOR);
  endfunction

  logic [1:0] sel;
  logic [3:0] mode;
  logic       two_speed;
  logic       pup_en;
  logic       xin_edge;
  src_e       desired;

  assign sel       = r.ctrl[CTRL_SEL_LSB +: 2];
  assign mode      = r.ctrl[CTRL_MODE_LSB +: 4];
  assign two_speed = r.ctrl[CTRL_TWO_BIT];
  assign pup_en    = r.ctrl[CTRL_PUP_BIT];
  assign xin_edge  = r.xin_sync[1] & ~r.xin_prev;

  always_comb
  begin
    if (sel == SEL_PRIMARY)
    begin
      desired = SRC_PRIMARY;
    end
    else if (sel == SEL_SLOW)
    begin
      desired = SRC_SLOW;
    end
    else
    begin
      desired = r.ctrl[CTRL_IRC_BIT] ? SRC_MID : SRC_FAST;
    end
  end

  function automatic logic src_tick(input src_e s);
    unique case (s)
      SRC_PRIMARY: return (is_crystal(mode) || is_driven(mode)) ?
                          xin_edge : fast_tick;
      SRC_FAST:    return fast_tick;
      SRC_MID:     return mid_tick;
      SRC_SLOW:    return slow_tick;
    endcase
  endfunction

  function automatic state_e entry_state(input src_e s);
    if (s != SRC_PRIMARY)
    begin
      return S_INT_WAIT;
    end
    // crystal modes go through the edge count
    if (is_crystal(mode))
    begin
      return S_COUNT;
    end
    // driven clock skips the edge count
    if (is_driven(mode))
    begin
      return S_EXT_WAIT;
    end
    return S_INT_WAIT;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [31:0] merged;
    logic [31:0] rd;
    logic        hit;
    logic        tgt_tick;
    merged   = r.ctrl;
    rd       = 32'h0000_0000;
    hit      = 1'b0;
    nxt      = r;
    tgt_tick = src_tick(r.target);

    nxt.xin_sync = {r.xin_sync[0], crystal_in_i};
    nxt.xin_prev = r.xin_sync[1];

    unique case (r.st)
      S_PUP:
      begin
        // optional power-up delay before the edge count
        if (!pup_en || r.cnt == CNT_W'(PUP_CYCLES_P - 1))
        begin
          nxt.st     = entry_state(desired);
          nxt.target = desired;
          nxt.cnt    = '0;
        end
        else
        begin
          nxt.cnt = r.cnt + CNT_W'(1);
        end
      end
      S_COUNT:
      begin
        if (xin_edge)
        begin
          if (r.cnt == CNT_W'(XTAL_EDGES - 1))
          begin
            nxt.cnt = '0;
            nxt.st  = (mode == MODE_TIMES_FOUR) ? S_PLL : S_RUN;
            if (mode != MODE_TIMES_FOUR)
            begin
              nxt.active = r.target;
            end
          end
          else
          begin
            nxt.cnt = r.cnt + CNT_W'(1);
          end
        end
      end
      S_PLL:
      begin
        if (r.cnt == CNT_W'(PLL_CYCLES_P - 1))
        begin
          nxt.st     = S_RUN;
          nxt.active = r.target;
          nxt.cnt    = '0;
        end
        else
        begin
          nxt.cnt = r.cnt + CNT_W'(1);
        end
      end
      S_EXT_WAIT:
      begin
        // two instruction cycles of the new source
        if (tgt_tick)
        begin
          if (r.cnt == CNT_W'(EXT_WAIT_EDGES - 1))
          begin
            nxt.st     = S_RUN;
            nxt.active = r.target;
            nxt.cnt    = '0;
          end
          else
          begin
            nxt.cnt = r.cnt + CNT_W'(1);
          end
        end
      end
      S_INT_WAIT:
      begin
        if (r.cnt == CNT_W'(ISTART_CYC - 1))
        begin
          nxt.st     = S_RUN;
          nxt.active = r.target;
          nxt.cnt    = '0;
        end
        else
        begin
          nxt.cnt = r.cnt + CNT_W'(1);
        end
      end
      S_RUN:
      begin
        if (sleep_i)
        begin
          nxt.st = S_SLEEP;
        end
        else if (desired != r.active)
        begin
          nxt.target = desired;
          nxt.cnt    = '0;
          nxt.phase  = 1'b0;
          nxt.st = (desired == SRC_PRIMARY && is_crystal(mode)) ?
                   S_COUNT : S_SWITCH;
        end
      end
      S_SWITCH:
      begin
        if (r.active == SRC_SLOW && r.target == SRC_PRIMARY &&
            is_driven(mode))
        begin
          // one old cycle, then one new cycle
          if (!r.phase && slow_tick)
          begin
            nxt.phase = 1'b1;
          end
          else if (r.phase && tgt_tick)
          begin
            nxt.st     = S_RUN;
            nxt.active = r.target;
          end
        end
        else if (r.active == SRC_SLOW && r.target != SRC_PRIMARY)
        begin
          // about 1 us between internal sources
          if (r.cnt == CNT_W'(SWITCH_CYC - 1))
          begin
            nxt.st     = S_RUN;
            nxt.active = r.target;
            nxt.cnt    = '0;
          end
          else
          begin
            nxt.cnt = r.cnt + CNT_W'(1);
          end
        end
        else if (tgt_tick)
        begin
          // one edge of the new source
          nxt.st     = S_RUN;
          nxt.active = r.target;
        end
      end
      S_SLEEP:
      begin
        // wake restarts the sequence without the power-up delay
        if (wake_i)
        begin
          nxt.st     = entry_state(desired);
          nxt.target = desired;
          nxt.cnt    = '0;
        end
      end
    endcase

    if (brownout_i)
    begin
      nxt.st    = S_PUP;
      nxt.cnt   = '0;
      nxt.phase = 1'b0;
    end

    // enable only on real source edges
    if (r.st == S_RUN || r.st == S_SWITCH)
    begin
      nxt.clk_en = src_tick(r.active);
    end
    else if (two_speed && (r.st == S_COUNT || r.st == S_PLL))
    begin
      nxt.clk_en = fast_tick;
    end
    else
    begin
      nxt.clk_en = 1'b0;
    end

    // output pin freed outside crystal modes
    nxt.xout_oe = is_crystal(mode) ? 1'b1 : gpio_oe_i;
    nxt.xout    = is_crystal(mode) ? ~r.xin_sync[1] : gpio_out_i;

    // Register bus: write path
    if (axil_req_i.awvalid && axil_rsp_o.awready)
    begin
      nxt.aw_got = 1'b1;
      nxt.awaddr = axil_req_i.awaddr[ADDR_W-1:0];
    end
    if (axil_req_i.wvalid && axil_rsp_o.wready)
    begin
      nxt.w_got = 1'b1;
      nxt.wdata = axil_req_i.wdata;
      nxt.wstrb = axil_req_i.wstrb;
    end
    for (int i = 0; i < 4; i++)
    begin
      if (r.wstrb[i])
      begin
        merged[8*i +: 8] = (r.wdata[8*i +: 8] & CTRL_WMASK[8*i +: 8]) |
                           (r.ctrl[8*i +: 8] & ~CTRL_WMASK[8*i +: 8]);
      end
    end
    if (r.aw_got && r.w_got)
    begin
      nxt.aw_got = 1'b0;
      nxt.w_got  = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp  = RESP_OKAY;
      if (r.awaddr == CTRL_OFS)
      begin
        nxt.ctrl = merged;
      end
      else if (r.awaddr != STAT_OFS && r.awaddr != CNT_OFS)
      begin
        nxt.bresp = RESP_SLVERR;
      end
    end
    if (r.bvalid && axil_req_i.bready)
    begin
      nxt.bvalid = 1'b0;
    end

    // Register bus: read path
    unique case (axil_req_i.araddr[ADDR_W-1:0])
      CTRL_OFS:
      begin
        rd  = r.ctrl;
        hit = 1'b1;
      end
      STAT_OFS:
      begin
        rd[STAT_RUN_BIT]     = run_o;
        rd[STAT_BUSY_BIT]    = startup_busy_o;
        rd[STAT_SRC_LSB +: 2] = r.active;
        rd[STAT_ST_LSB +: 4]  = r.st;
        hit = 1'b1;
      end
      CNT_OFS:
      begin
        rd[CNT_W-1:0] = r.cnt;
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    if (axil_req_i.arvalid && axil_rsp_o.arready)
    begin
      nxt.rvalid = 1'b1;
      nxt.rdata  = rd;
      nxt.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r.rvalid && axil_req_i.rready)
    begin
      nxt.rvalid = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r      <= '0;
      r.ctrl <= CTRL_RST;
    end
    else
    begin
      r <= nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // execution held while counting, unless two-speed start-up is on
  assign run_o = (r.st == S_RUN) || (r.st == S_SWITCH) ||
                 (two_speed && (r.st == S_COUNT || r.st == S_PLL));
  assign startup_busy_o   = (r.st != S_RUN) && (r.st != S_SLEEP);
  assign sys_clk_en_o     = r.clk_en;
  assign active_src_o     = r.active;
  assign crystal_out_o    = r.xout;
  assign crystal_out_oe_o = r.xout_oe;

  assign axil_rsp_o.awready = !r.aw_got && !r.bvalid;
  assign axil_rsp_o.wready  = !r.w_got && !r.bvalid;
  assign axil_rsp_o.bvalid  = r.bvalid;
  assign axil_rsp_o.bresp   = r.bresp;
  assign axil_rsp_o.arready = !r.rvalid;
  assign axil_rsp_o.rvalid  = r.rvalid;
  assign axil_rsp_o.rdata   = r.rdata;
  assign axil_rsp_o.rresp   = r.rresp;

endmodule
`default_nettype wire

// [tb/osc_startup_properties.sv]
// Port-level checks for the oscillator start-up controller
`timescale 1ns/10ps
`default_nettype none
module osc_startup_properties
  import osc_startup_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Register bus
  input  wire axil_req_s  axil_req_i,
  input  wire axil_rsp_s  axil_rsp_o,
  // Oscillator pins
  input  wire logic       crystal_in_i,
  input  wire logic       crystal_out_o,
  input  wire logic       crystal_out_oe_o,
  input  wire logic       gpio_out_i,
  input  wire logic       gpio_oe_i,
  // Core side
  input  wire logic       brownout_i,
  input  wire logic       sleep_i,
  input  wire logic       wake_i,
  input  wire logic       run_o,
  input  wire logic       sys_clk_en_o,
  input  wire logic       startup_busy_o,
  input  wire logic [1:0] active_src_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_wr_take;
    axil_req_i.awvalid && axil_rsp_o.awready &&
    axil_req_i.wvalid && axil_rsp_o.wready;
  endsequence
  sequence s_wr_answer;
    !axil_rsp_o.bvalid ##1 axil_rsp_o.bvalid;
  endsequence
  sequence s_held;
    (!run_o && startup_busy_o) [*8];
  endsequence

  property p_wr_resp;
    s_wr_take |=> s_wr_answer;
  endproperty
  property p_rd_resp;
    axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid;
  endproperty
  property p_b_clear;
    axil_rsp_o.bvalid && axil_req_i.bready |=> !axil_rsp_o.bvalid;
  endproperty
  property p_r_clear;
    axil_rsp_o.rvalid && axil_req_i.rready |=> !axil_rsp_o.rvalid;
  endproperty
  property p_refuse;
    axil_rsp_o.bvalid |-> !axil_rsp_o.awready && !axil_rsp_o.wready;
  endproperty
  // Two cycles of busy so a late enable after leaving run (brownout, switch into the count) is not flagged
  property p_hold_pc;
    !run_o && startup_busy_o && $past(startup_busy_o) && !$past(run_o)
      |-> !sys_clk_en_o;
  endproperty
  property p_gpio_oe;
    !crystal_out_oe_o && $past(rst_b_i) |-> !$past(gpio_oe_i);
  endproperty
  property p_gpio_out;
    !crystal_out_oe_o && $past(rst_b_i)
      |-> crystal_out_o == $past(gpio_out_i);
  endproperty
  property p_start_held;
    $rose(rst_b_i) |-> s_held;
  endproperty

  a_wr_resp: assert property (p_wr_resp)
    else $error("write answer not two cycles after take");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read answer not one cycle after take");
  a_b_clear: assert property (p_b_clear)
    else $error("write answer not cleared");
  a_r_clear: assert property (p_r_clear)
    else $error("read answer not cleared");
  a_refuse: assert property (p_refuse)
    else $error("write taken while answer pending");
  a_hold_pc: assert property (p_hold_pc)
    else $error("clock enable while execution held");
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("freed pin enable differs from gpio");
  a_gpio_out: assert property (p_gpio_out)
    else $error("freed pin value differs from gpio");
  a_start_held: assert property (p_start_held)
    else $error("execution not held after power-on");
endmodule

bind osc_startup_ctrl osc_startup_properties props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .axil_req_i(axil_req_i),
  .axil_rsp_o(axil_rsp_o), .crystal_in_i(crystal_in_i),
  .crystal_out_o(crystal_out_o), .crystal_out_oe_o(crystal_out_oe_o),
  .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .brownout_i(brownout_i),
  .sleep_i(sleep_i), .wake_i(wake_i), .run_o(run_o),
  .sys_clk_en_o(sys_clk_en_o), .startup_busy_o(startup_busy_o),
  .active_src_o(active_src_o));
`default_nettype wire

// [tb/crystal_src_model.sv]
// Behavioural crystal or driven clock source on the input pin
`timescale 1ns/10ps
`default_nettype none
module crystal_src_model #(
  parameter int HALF_NS = 21
) (
  // Control
  input  wire logic run_i,
  // Pin
  output logic      osc_o
);
  // ****************************************
  // Oscillation
  // ****************************************
  initial osc_o = 1'b0;
  // logic-level swing
  // Stands still when stopped, like a crystal that has not started
  always
  begin
    wait (run_i);
    #(HALF_NS) osc_o = ~osc_o;
  end
endmodule
`default_nettype wire

// [tb/oscillator_startup_select_bench.sv]
// Self-checking bench for oscillator selection and start-up control
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module oscillator_startup_select_bench
  import osc_startup_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  axil_req_s   req;
  axil_rsp_s   rsp;
  logic        xtal, xtal_run, gpio_out, gpio_oe, brownout, slp, wake;
  logic        xout, xoe, run, clk_en, busy;
  logic [1:0]  src, r;
  logic [31:0] d;
  int          fails, num_checks, edges, cyc;
  logic [31:0] ctrl_t [9] = '{32'h010, 32'h110, 32'h210, 32'h310,
                              32'h410, 32'h510, 32'h610, 32'h710, 32'h118};
  int          lo_t [9] = '{1024, 1024, 1024, 8, 8, 8, 8, 1025, 1024};
  int          hi_t [9] = '{1025, 1025, 1025, 9, 9, 9, 9, 1027, 1025};
  logic [31:0] sel_t [6] = '{32'h812, 32'h816, 32'h811, 32'h410,
                             32'h811, 32'h812};
  logic [1:0]  src_t [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};

  osc_startup_ctrl #(.PUP_CYCLES_P(8), .PLL_CYCLES_P(16),
                     .SLOW_DIV_P(64)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .axil_req_i(req), .axil_rsp_o(rsp),
    .crystal_in_i(xtal), .crystal_out_o(xout), .crystal_out_oe_o(xoe),
    .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .brownout_i(brownout),
    .sleep_i(slp), .wake_i(wake), .run_o(run), .sys_clk_en_o(clk_en),
    .startup_busy_o(busy), .active_src_o(src));
  crystal_src_model #(.HALF_NS(21)) xtal_src (.run_i(xtal_run),
                                              .osc_o(xtal));

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc++;
  always @(posedge xtal) edges++;

  // ****************************************
  // Bus and sequence tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int   n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (n = 0; n < 64 && (aw || w); n++)
    begin
      @(posedge clk_i);
      aw = aw && !rsp.awready;
      w = w && !rsp.wready;
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    for (n = 0; n < 64 && !rsp.bvalid; n++)
      @(posedge clk_i);
    if (!rsp.bvalid)
      fails++;
    r = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    req.rready <= 1'b1;
    do @(posedge clk_i); while (!rsp.arready && ++n < 64);
    req.arvalid <= 1'b0;
    do @(posedge clk_i); while (!rsp.rvalid && ++n < 128);
    if (!rsp.rvalid)
      fails++;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  task automatic wait_up();
    int n;
    for (n = 0; n < 20000 && !(run && !busy); n++)
      @(posedge clk_i);
    if (!(run && !busy))
      fails++;
  endtask

  // Change mode, sleep, wake, then count pin edges up to run
  // Pin stopped over sleep: no stale edge in the synchroniser at wake
  task automatic restart(input logic [31:0] c, input int lo, input int hi);
    xtal_run <= 1'b0;
    wr(CTRL_OFS, c);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("run asleep", 1'b0, run)
    wake <= 1'b1;
    xtal_run <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    edges = 0;
    cyc = 0;
    repeat (20) @(posedge clk_i);
    `CHK("run early", c[CTRL_TWO_BIT], run)
    wait_up();
    `CHK("edges", 1'b1, edges >= lo && edges <= hi)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    int n;
    req = '0;
    {xtal_run, gpio_out, gpio_oe, brownout, slp, wake} = 6'h0;
    {fails, num_checks, edges, cyc} = '0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    `CHK("busy at reset", 1'b1, busy)
    rd(CTRL_OFS);
    `CHK("ctrl reset", CTRL_RST, d)
    rd(8'h0c);
    `CHK("unmapped", RESP_SLVERR, r)
    repeat (300) @(posedge clk_i);
    `CHK("run without pin", 1'b0, run)
    edges = 0;
    xtal_run <= 1'b1;
    wait_up();
    `CHK("first count", 1'b1, edges >= 1024 && edges <= 1025)
    `CHK("pin driven", 1'b1, xoe)
    brownout <= 1'b1;
    @(posedge clk_i);
    brownout <= 1'b0;
    repeat (4000) @(posedge clk_i);
    `CHK("run mid count", 1'b0, run)
    brownout <= 1'b1;
    @(posedge clk_i);
    brownout <= 1'b0;
    edges = 0;
    wait_up();
    `CHK("recount", 1'b1, edges >= 1024 && edges <= 1026)
    foreach (ctrl_t[i])
      restart(ctrl_t[i], lo_t[i], hi_t[i]);
    `CHK("write resp", RESP_OKAY, r)
    restart(32'h810, 0, 100000);
    `CHK("internal delay", 1'b1, cyc >= 1000 && cyc <= 1012)
    foreach (sel_t[i])
    begin
      wr(CTRL_OFS, sel_t[i]);
      cyc = 0;
      `CHK("run in switch", 1'b1, run)
      for (n = 0; n < 2000 && src !== src_t[i]; n++)
        @(posedge clk_i);
      `CHK("source", src_t[i], src)
      if (i == 3)
        `CHK("slow to driven", 1'b1, cyc >= 2 && cyc <= 80)
    end
    `CHK("slow to fast", 1'b1, cyc >= 195 && cyc <= 215)
    gpio_oe <= 1'b1;
    gpio_out <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("gpio oe", 1'b1, xoe)
    `CHK("gpio out", 1'b1, xout)
    wr(CTRL_OFS, 32'hffff_ffff);
    rd(CTRL_OFS);
    `CHK("ctrl mask", CTRL_WMASK, d)
    conclude();
  end

  // Whole run is near 70k cycles; cut a hang well past that
  initial
  begin
    #450us;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
